// ==== mbi_crc.sv ====
// byte-wide crc-16 engine, shared by receive check and transmit append
`timescale 1ns/1ps
module mbi_crc
  import mbi_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  mbi_crc_if.engine crc_bus
);
  logic [15:0] crc_q;
  logic [15:0] crc_d;
  logic [15:0] base;

  // clear and first byte may come together, so fold from the initial value
  always_comb
  begin
    base = crc_bus.clr ? CRC_INIT : crc_q;
    crc_d = base;
    if (crc_bus.en)
    begin
      crc_d = base ^ {8'h00, crc_bus.data};
      for (int i = 0; i < 8; i++)
      begin
        crc_d = crc_d[0] ? ((crc_d >> 1) ^ CRC_POLY) : (crc_d >> 1);
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      crc_q <= CRC_INIT;
    else
      crc_q <= crc_d;
  end

  assign crc_bus.crc = crc_q;
endmodule

// ==== mbi_crc_if.sv ====
// crc request and result bundle between the sequencer and the crc engine
`timescale 1ns/1ps
interface mbi_crc_if;
  logic clr;
  logic en;
  logic [7:0] data;
  logic [15:0] crc;
  modport user (output clr, output en, output data, input crc);
  modport engine (input clr, input en, input data, output crc);
endinterface

// ==== mbi_ident_slave.sv ====
// rtu slave: identification answers, telegram checks, exceptions, watchdog
`timescale 1ns/1ps
module mbi_ident_slave
  import mbi_pkg::*;
#(
  parameter int unsigned GAP_CYC = GAP_CYCLES,
  parameter int unsigned TICK_CYC = TICK_CYCLES,
  parameter logic [8*OBJ_MAX-1:0] VENDOR_NAME = "VENDOR NAME",
  parameter logic [4:0] VENDOR_LEN = 5'h0b,
  parameter logic [8*OBJ_MAX-1:0] PRODUCT_CODE = "DRIVE 220 - 230 V 10 A",
  parameter logic [4:0] PRODUCT_LEN = 5'h16,
  // revision value is arbitrary
  parameter logic [8*OBJ_MAX-1:0] FW_REVISION = "V0.01",
  parameter logic [4:0] FW_REV_LEN = 5'h05
)
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [7:0] slave_addr,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_parity_err,
  input wire logic tx_ready,
  input wire logic [15:0] comm_timeout_period,
  input wire logic timeout_action_select,
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic telegram_valid,
  output logic comm_timeout_alarm,
  output logic comm_timeout_fault
);
  localparam int GW = $clog2(GAP_CYC + 1);
  localparam int TW = $clog2(TICK_CYC + 1);

  // reset release through two flops
  logic [1:0] rst_sync_q;
  logic rst_n;
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      rst_sync_q <= 2'b00;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  mbi_crc_if crc_bus ();
  mbi_crc u_crc (
    .clock(clock),
    .rst_n(rst_n),
    .crc_bus(crc_bus)
  );

  mbi_state_e st_q, st_d;
  logic [7:0] buf_q [BUF_DEPTH];
  logic [7:0] buf_d [BUF_DEPTH];
  logic [7:0] cnt_q, cnt_d;
  logic perr_q, perr_d;
  logic [GW-1:0] gap_q, gap_d;
  logic exc_q, exc_d;
  logic [7:0] code_q, code_d;
  logic [2:0] hidx_q, hidx_d;
  logic [1:0] obj_q, obj_d;
  logic [1:0] first_q, first_d;
  logic [1:0] left_q, left_d;
  logic [4:0] pos_q, pos_d;
  logic tx_valid_d, tv_d;
  logic [7:0] tx_data_d;
  logic tx_load;
  logic frame_good;
  logic [7:0] head_byte, obj_byte;
  logic [4:0] obj_len [NUM_OBJ];
  logic [8*OBJ_MAX-1:0] obj_str [NUM_OBJ];
  logic [7:0] obj_char [NUM_OBJ];

  assign obj_str[0] = VENDOR_NAME;
  assign obj_str[1] = PRODUCT_CODE;
  assign obj_str[2] = FW_REVISION;
  assign obj_len[0] = VENDOR_LEN;
  assign obj_len[1] = PRODUCT_LEN;
  assign obj_len[2] = FW_REV_LEN;

  // strings are right justified, so character pos-2 sits len-1-(pos-2) bytes up
  for (genvar g = 0; g < NUM_OBJ; g++)
  begin : g_obj
    logic [4:0] bidx;
    assign bidx = obj_len[g] + 5'h01 - pos_q;
    assign obj_char[g] = obj_str[g][8 * bidx +: 8];
  end

  // byte to send in header and object phases
  always_comb
  begin
    head_byte = 8'h00;
    if (exc_q)
    begin
      unique case (hidx_q)
        3'h0: head_byte = slave_addr;
        3'h1: head_byte = buf_q[1] | EXC_FLAG;
        default: head_byte = code_q;
      endcase
    end
    else
    begin
      unique case (hidx_q)
        3'h0: head_byte = slave_addr;
        3'h1: head_byte = FUNC_IDENT;
        3'h2: head_byte = MEI_IDENT;
        3'h3: head_byte = code_q;
        3'h4: head_byte = CONFORMITY;
        3'h5: head_byte = MORE_FOLLOWS;
        3'h6: head_byte = NEXT_OBJ;
        default: head_byte = {6'h00, left_q};
      endcase
    end
    if (pos_q == 5'h00)
      obj_byte = {6'h00, obj_q};
    else if (pos_q == 5'h01)
      obj_byte = {3'h0, obj_len[obj_q]};
    else
      obj_byte = obj_char[obj_q];
  end

  assign tx_load = (st_q == ST_HEAD || st_q == ST_OBJ || st_q == ST_CRC_LO || st_q == ST_CRC_HI) && !tx_valid;
  assign frame_good = cnt_q >= MIN_FRAME && crc_bus.crc == CRC_GOOD && !perr_q && buf_q[0] == slave_addr;

  // receive, decide and transmit; bytes arriving while answering are ignored
  always_comb
  begin
    st_d = st_q;
    buf_d = buf_q;
    cnt_d = cnt_q;
    perr_d = perr_q;
    gap_d = gap_q;
    exc_d = exc_q;
    code_d = code_q;
    hidx_d = hidx_q;
    obj_d = obj_q;
    first_d = first_q;
    left_d = left_q;
    pos_d = pos_q;
    tv_d = 1'b0;
    tx_valid_d = tx_valid && !tx_ready;
    tx_data_d = tx_data;
    crc_bus.clr = 1'b0;
    crc_bus.en = 1'b0;
    crc_bus.data = 8'h00;
    unique case (st_q)
      ST_IDLE:
      begin
        if (rx_valid)
        begin
          crc_bus.clr = 1'b1;
          crc_bus.en = 1'b1;
          crc_bus.data = rx_data;
          buf_d[0] = rx_data;
          cnt_d = 8'h01;
          perr_d = rx_parity_err;
          gap_d = '0;
          st_d = ST_RECV;
        end
      end
      ST_RECV:
      begin
        if (rx_valid)
        begin
          crc_bus.en = 1'b1;
          crc_bus.data = rx_data;
          if (cnt_q < 8'(BUF_DEPTH))
            buf_d[cnt_q[2:0]] = rx_data;
          if (cnt_q != 8'hff)
            cnt_d = cnt_q + 8'h01;
          perr_d = perr_q | rx_parity_err;
          gap_d = '0;
        end
        else if (gap_q == GW'(GAP_CYC - 1))
          st_d = ST_EVAL;
        else
          gap_d = gap_q + GW'(1);
      end
      ST_EVAL:
      begin
        crc_bus.clr = 1'b1;
        hidx_d = 3'h0;
        exc_d = 1'b1;
        if (!frame_good)
          st_d = ST_IDLE;
        else
        begin
          tv_d = 1'b1;
          st_d = ST_HEAD;
          if (buf_q[1] != FUNC_IDENT || buf_q[2] != MEI_IDENT)
            code_d = EXC_FUNC;
          else if (cnt_q != IDENT_REQ_LEN || (buf_q[3] != RD_SEQ && buf_q[3] != RD_ONE))
            code_d = EXC_VALUE;
          else if (buf_q[4] > OBJ_LAST)
            code_d = EXC_ADDR;
          else
          begin
            exc_d = 1'b0;
            code_d = buf_q[3];
            first_d = buf_q[4][1:0];
            left_d = (buf_q[3] == RD_SEQ) ? 2'h3 - buf_q[4][1:0] : 2'h1;
          end
        end
      end
      ST_HEAD:
      begin
        if (tx_load)
        begin
          tx_valid_d = 1'b1;
          tx_data_d = head_byte;
          crc_bus.en = 1'b1;
          crc_bus.data = head_byte;
          hidx_d = hidx_q + 3'h1;
          if (exc_q && hidx_q == EXC_LAST)
            st_d = ST_CRC_LO;
          else if (!exc_q && hidx_q == HEAD_LAST)
          begin
            st_d = ST_OBJ;
            obj_d = first_q;
            pos_d = 5'h00;
          end
        end
      end
      ST_OBJ:
      begin
        if (tx_load)
        begin
          tx_valid_d = 1'b1;
          tx_data_d = obj_byte;
          crc_bus.en = 1'b1;
          crc_bus.data = obj_byte;
          pos_d = pos_q + 5'h01;
          if (pos_q == obj_len[obj_q] + 5'h01)
          begin
            pos_d = 5'h00;
            obj_d = obj_q + 2'h1;
            left_d = left_q - 2'h1;
            if (left_q == 2'h1)
              st_d = ST_CRC_LO;
          end
        end
      end
      ST_CRC_LO:
      begin
        if (tx_load)
        begin
          tx_valid_d = 1'b1;
          tx_data_d = crc_bus.crc[7:0];
          st_d = ST_CRC_HI;
        end
      end
      ST_CRC_HI:
      begin
        if (tx_load)
        begin
          tx_valid_d = 1'b1;
          tx_data_d = crc_bus.crc[15:8];
          st_d = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= ST_IDLE;
      for (int i = 0; i < BUF_DEPTH; i++)
        buf_q[i] <= 8'h00;
      cnt_q <= 8'h00;
      perr_q <= 1'b0;
      gap_q <= '0;
      exc_q <= 1'b0;
      code_q <= 8'h00;
      hidx_q <= 3'h0;
      obj_q <= 2'h0;
      first_q <= 2'h0;
      left_q <= 2'h0;
      pos_q <= 5'h00;
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
      telegram_valid <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      buf_q <= buf_d;
      cnt_q <= cnt_d;
      perr_q <= perr_d;
      gap_q <= gap_d;
      exc_q <= exc_d;
      code_q <= code_d;
      hidx_q <= hidx_d;
      obj_q <= obj_d;
      first_q <= first_d;
      left_q <= left_d;
      pos_q <= pos_d;
      tx_valid <= tx_valid_d;
      tx_data <= tx_data_d;
      telegram_valid <= tv_d;
    end
  end

  // watchdog in 100 ms ticks; the fault stays until reset, only the alarm heals
  logic armed_q, armed_d;
  logic [TW-1:0] tick_q, tick_d;
  logic [15:0] wd_q, wd_d;
  logic alarm_d, fault_d, tick_hit, expire;
  always_comb
  begin
    armed_d = armed_q | telegram_valid;
    tick_hit = armed_q && tick_q == TW'(TICK_CYC - 1);
    tick_d = (!armed_q || telegram_valid || tick_hit) ? '0 : tick_q + TW'(1);
    expire = tick_hit && comm_timeout_period != 16'h0000 && 17'(wd_q) + 17'h1 >= 17'(comm_timeout_period);
    wd_d = wd_q;
    if (telegram_valid)
      wd_d = 16'h0000;
    else if (tick_hit && wd_q != 16'hffff)
      wd_d = wd_q + 16'h0001;
    alarm_d = comm_timeout_alarm;
    if (expire && !timeout_action_select)
      alarm_d = 1'b1;
    else if (telegram_valid)
      alarm_d = 1'b0;
    fault_d = comm_timeout_fault | (expire && timeout_action_select);
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      armed_q <= 1'b0;
      tick_q <= '0;
      wd_q <= 16'h0000;
      comm_timeout_alarm <= 1'b0;
      comm_timeout_fault <= 1'b0;
    end
    else
    begin
      armed_q <= armed_d;
      tick_q <= tick_d;
      wd_q <= wd_d;
      comm_timeout_alarm <= alarm_d;
      comm_timeout_fault <= fault_d;
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  AST_DROP_BAD: assert property ((st_q == ST_EVAL && !frame_good) |=> (st_q == ST_IDLE && !tx_valid))
    else $error("bad telegram was not dropped");
  AST_GAP_END: assert property ((st_q == ST_RECV && !rx_valid && gap_q == GW'(GAP_CYC - 1)) |=> st_q == ST_EVAL)
    else $error("frame did not close after gap");
  AST_CONFORM: assert property ((st_q == ST_HEAD && tx_load && !exc_q && hidx_q == 3'h4) |=> tx_data == CONFORMITY)
    else $error("conformity byte wrong");
  AST_EXC_MSB: assert property ((st_q == ST_HEAD && tx_load && exc_q && hidx_q == 3'h1) |=> tx_data[7])
    else $error("exception function lacks msb");
  AST_CRC_LOW: assert property ((st_q == ST_CRC_LO && tx_load) |=> (tx_data == crc_bus.crc[7:0] && st_q == ST_CRC_HI))
    else $error("crc low byte not sent first");
  AST_IDLE_WD: assert property (!armed_q |-> (!comm_timeout_alarm && !comm_timeout_fault))
    else $error("watchdog fired before first valid telegram");
  AST_ACTION: assert property ($rose(comm_timeout_fault) |-> $past(timeout_action_select))
    else $error("fault raised with alarm selected");
  AST_HEAL: assert property ((telegram_valid && !expire) |=> !comm_timeout_alarm)
    else $error("alarm not cleared by valid telegram");
  AST_DISABLED: assert property ((comm_timeout_period == 16'h0000) |=> !$rose(comm_timeout_alarm))
    else $error("alarm raised while supervision disabled");
  AST_EXPIRE: assert property (expire |=> (comm_timeout_alarm || comm_timeout_fault))
    else $error("timeout not flagged");
endmodule

// ==== mbi_ident_slave_tb.sv ====
// self-checking bench for the identification slave
`timescale 1ns/1ps
module mbi_ident_slave_tb
  import mbi_pkg::*;
;
  localparam int unsigned GAP = 20;
  localparam int unsigned TICK = 50;
  localparam logic [7:0] ADDR = 8'h11;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic [15:0] comm_timeout_period = 16'h0001;
  logic timeout_action_select = 1'b0;
  logic rx_valid, rx_parity_err, tx_ready, tx_valid, telegram_valid;
  logic comm_timeout_alarm, comm_timeout_fault;
  logic [7:0] rx_data, tx_data;
  int error_cnt = 0;
  int total_checks = 0;
  int tv_cnt = 0;
  string obj_str[3] = '{"VENDOR NAME", "DRIVE 220 - 230 V 10 A", "V0.01"};
  always #5 clock = ~clock;
  // count good-telegram pulses per scenario
  always @(posedge clock)
  begin
    if (telegram_valid === 1'b1)
      tv_cnt++;
  end
  mbi_ident_slave #(.GAP_CYC(GAP), .TICK_CYC(TICK)) mbi_ident_slave_i (
    .clock(clock), .reset_n(reset_n), .slave_addr(ADDR), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_parity_err(rx_parity_err), .tx_ready(tx_ready),
    .comm_timeout_period(comm_timeout_period), .timeout_action_select(timeout_action_select),
    .tx_valid(tx_valid), .tx_data(tx_data), .telegram_valid(telegram_valid),
    .comm_timeout_alarm(comm_timeout_alarm), .comm_timeout_fault(comm_timeout_fault));
  mbi_master_model #(.GAP_CYC(GAP)) mbi_master_model_i (
    .clock(clock), .rx_valid(rx_valid), .rx_data(rx_data), .rx_parity_err(rx_parity_err),
    .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_data(tx_data));
  // bitwise crc, low byte first on the wire
  function automatic void add_crc(ref logic [7:0] q[$]);
    logic [15:0] c;
    c = CRC_INIT;
    foreach (q[i])
    begin
      c = c ^ {8'h00, q[i]};
      for (int b = 0; b < 8; b++)
        c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
  endfunction
  // sequential runs to the last object, individual returns one
  function automatic void ident_exp(ref logic [7:0] q[$], input logic [7:0] rc, input int o);
    int last;
    last = (rc == RD_SEQ) ? 2 : o;
    q = '{ADDR, 8'h2b, 8'h0e, rc, 8'h81, 8'h00, 8'h00, 8'(last - o + 1)};
    for (int k = o; k <= last; k++)
    begin
      q.push_back(8'(k));
      q.push_back(8'(obj_str[k].len()));
      for (int i = 0; i < obj_str[k].len(); i++)
        q.push_back(obj_str[k][i]);
    end
  endfunction
  task check8(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task check1(input logic g, input logic e);
    check8({7'h00, g}, {7'h00, e});
  endtask
  task end_sim;
    if (error_cnt == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // one request, then the full reply (or silence) and the pulse count
  task run(input logic [7:0] req[$], input logic [7:0] exp[$], input int par_idx, input int gap_idx,
           input bit bad_crc, input int exp_tv);
    logic [7:0] fr[$];
    bit ok;
    fr = req;
    add_crc(fr);
    if (bad_crc)
      fr[fr.size() - 1] ^= 8'h01;
    if (exp.size() > 0)
      add_crc(exp);
    @(negedge clock);
    mbi_master_model_i.got.delete();
    tv_cnt = 0;
    mbi_master_model_i.send(fr, par_idx, gap_idx);
    mbi_master_model_i.wait_reply((exp.size() > 0) ? exp.size() : 1, (exp.size() > 0) ? 1000 : GAP + 60, ok);
    check1(ok, exp.size() > 0);
    // a missing reply ends the whole simulation at once, counted as a mismatch above
    if (!ok && exp.size() > 0)
      end_sim();
    else
    begin
      repeat (10) @(negedge clock);
      check8(8'(mbi_master_model_i.got.size()), 8'(exp.size()));
      foreach (exp[i])
        if (i < mbi_master_model_i.got.size())
          check8(mbi_master_model_i.got[i], exp[i]);
      check8(8'(tv_cnt), 8'(exp_tv));
    end
  endtask
  // main sequence
  initial
  begin
    logic [7:0] exp[$];
    logic [7:0] none[$];
    logic [7:0] q0[$];
    q0 = '{ADDR, FUNC_IDENT, MEI_IDENT, RD_ONE, 8'h02};
    repeat (20) @(negedge clock);
    reset_n = 1'b1;
    repeat (205) @(negedge clock);
    check1(comm_timeout_alarm, 1'b0);
    check1(comm_timeout_fault, 1'b0);
    comm_timeout_period = 16'h0000;
    for (int r = 0; r < 2; r++)
      for (int o = 0; o < 3; o++)
      begin
        ident_exp(exp, r ? RD_ONE : RD_SEQ, o);
        run('{ADDR, 8'h2b, 8'h0e, r ? RD_ONE : RD_SEQ, 8'(o)}, exp, -1, -1, 0, 1);
      end
    check1(comm_timeout_alarm, 1'b0);
    check1(comm_timeout_fault, 1'b0);
    run('{ADDR, 8'h2b, 8'h0e, 8'h01, 8'h03}, '{ADDR, 8'hab, 8'h02}, -1, -1, 0, 1);
    run('{ADDR, 8'h2b, 8'h0e, 8'h02, 8'h00}, '{ADDR, 8'hab, 8'h03}, -1, -1, 0, 1);
    run('{ADDR, 8'h2b, 8'h0e, 8'h04, 8'h00, 8'h00}, '{ADDR, 8'hab, 8'h03}, -1, -1, 0, 1);
    run('{ADDR, 8'h03, 8'h00, 8'h02, 8'h00, 8'h02}, '{ADDR, 8'h83, 8'h01}, -1, -1, 0, 1);
    run('{ADDR, 8'h2b, 8'h0d, 8'h01, 8'h00}, '{ADDR, 8'hab, 8'h01}, -1, -1, 0, 1);
    run(q0, none, -1, -1, 1, 0);
    run(q0, none, 2, -1, 0, 0);
    run(q0, none, -1, 3, 0, 0);
    run('{ADDR + 8'h01, 8'h2b, 8'h0e, 8'h04, 8'h02}, none, -1, -1, 0, 0);
    ident_exp(exp, RD_ONE, 2);
    comm_timeout_period = 16'h0001;
    run(q0, exp, -1, -1, 0, 1);
    repeat (2 * TICK + 10) @(negedge clock);
    check1(comm_timeout_alarm, 1'b1);
    check1(comm_timeout_fault, 1'b0);
    comm_timeout_period = 16'h00c8;
    run(q0, exp, -1, -1, 0, 1);
    check1(comm_timeout_alarm, 1'b0);
    comm_timeout_period = 16'h0001;
    timeout_action_select = 1'b1;
    run(q0, exp, -1, -1, 0, 1);
    repeat (2 * TICK + 10) @(negedge clock);
    check1(comm_timeout_fault, 1'b1);
    check1(comm_timeout_alarm, 1'b0);
    end_sim();
  end
endmodule

// ==== mbi_master_model.sv ====
// bus master stand-in: sends request frames, collects response bytes
`timescale 1ns/1ps
module mbi_master_model
#(
  parameter int unsigned GAP_CYC = 20
)
(
  input wire logic clock,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_parity_err,
  output logic tx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data
);
  integer seed = 32'h493f82b2;
  logic [1:0] pace = 2'h0;
  logic [7:0] got[$];
  initial
  begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_parity_err = 1'b0;
    tx_ready = 1'b0;
  end
  // random stalls; pacing stays far below the frame gap
  always @(negedge clock)
  begin
    tx_ready <= ($random(seed) & 3) != 0;
    pace <= 2'($random(seed));
  end
  // a byte is taken on the edge where valid meets ready
  always @(posedge clock)
  begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1)
      got.push_back(tx_data);
  end
  // one byte a pulse; released data shows the inverse, not a stale copy
  task send(input logic [7:0] fr[$], input int par_idx, input int gap_idx);
    for (int i = 0; i < fr.size(); i++)
    begin
      if (i == gap_idx)
        repeat (GAP_CYC + 5) @(negedge clock);
      @(negedge clock);
      rx_valid = 1'b1;
      rx_data = fr[i];
      rx_parity_err = (i == par_idx);
      @(negedge clock);
      rx_valid = 1'b0;
      rx_data = ~fr[i];
      rx_parity_err = 1'b0;
      repeat (pace) @(negedge clock);
    end
  endtask
  // own reply timeout; ok low means no answer came in time
  task wait_reply(input int n, input int limit, output bit ok);
    ok = 1'b0;
    for (int c = 0; c < limit && !ok; c++)
    begin
      @(negedge clock);
      ok = got.size() >= n;
    end
  endtask
endmodule

// ==== mbi_pkg.sv ====
// constants and types shared by the identification slave and its crc engine
package mbi_pkg;
  // telegram field values
  localparam logic [7:0] FUNC_IDENT = 8'h2b;
  localparam logic [7:0] MEI_IDENT = 8'h0e;
  localparam logic [7:0] RD_SEQ = 8'h01;
  localparam logic [7:0] RD_ONE = 8'h04;
  localparam logic [7:0] CONFORMITY = 8'h81;
  localparam logic [7:0] MORE_FOLLOWS = 8'h00;
  localparam logic [7:0] NEXT_OBJ = 8'h00;
  localparam logic [7:0] OBJ_LAST = 8'h02;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_FUNC = 8'h01;
  localparam logic [7:0] EXC_ADDR = 8'h02;
  localparam logic [7:0] EXC_VALUE = 8'h03;
  localparam logic [7:0] IDENT_REQ_LEN = 8'h07;
  localparam logic [7:0] MIN_FRAME = 8'h04;
  localparam logic [2:0] HEAD_LAST = 3'h7;
  localparam logic [2:0] EXC_LAST = 3'h2;
  // crc-16, reflected polynomial; a frame with its own crc appended leaves zero
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'ha001;
  localparam logic [15:0] CRC_GOOD = 16'h0000;
  // timing: 3.5 characters of 11 bits at 19200 baud, watchdog unit of 100 ms
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned GAP_TIME_NS = 2005209;
  localparam int unsigned GAP_CYCLES = (GAP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TICK_TIME_NS = 100000000;
  localparam int unsigned TICK_CYCLES = TICK_TIME_NS / CLK_PERIOD_NS;
  // storage sizes
  localparam int unsigned BUF_DEPTH = 8;
  localparam int unsigned OBJ_MAX = 24;
  localparam int unsigned NUM_OBJ = 3;
  // sequencer states, gray coded along the receive then transmit path
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RECV = 3'b001,
    ST_EVAL = 3'b011,
    ST_HEAD = 3'b010,
    ST_OBJ = 3'b110,
    ST_CRC_LO = 3'b111,
    ST_CRC_HI = 3'b101
  } mbi_state_e;
endpackage
